// ===== flash_pkg.sv
// How it works
// - Store holds 64k main bytes plus a separate 128-byte sector.
// - Single-byte programming is taken from the debug port and from software.
// - Programming only clears bits; new byte is old AND written data.
// - Erase sets every byte of a whole 512-byte page, or of the whole 128-byte sector when it is selected, to 0xff.
// - With store write enable set, data-space writes become flash programming.
// - Store write enable stays set until software clears it.
// - Data-space reads always go to external data RAM.
// - Flash contents reach the core only through code-space reads.
// - Software writes and erases need the flash write/erase enable bit set.
// - With all three enables set, a redirected write erases its page, or the whole sector while scratchpad select is set.
// - Writes and erases are timed in hardware, no polling needed.
// - The core is stalled while a program or erase runs.
// - Interrupts arriving during an operation are held until it completes.
// - Scratchpad sector at 0x00-0x7f is mapped only while scratchpad select is set.
// - Instructions are never fetched from the scratchpad sector.
package flash_pkg;

    // ==================================================
    // Geometry
    localparam int MAIN_BYTES = 65536;
    localparam int SCRATCH_BYTES = 128;
    localparam int PAGE_BYTES = 512;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ==================================================
    // Register map
    localparam logic [1:0] REG_STORE_CTRL = 2'h0;
    localparam logic [1:0] REG_SCALE_CTRL = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam int STORE_WE_BIT = 0;
    localparam int STORE_EE_BIT = 1;
    localparam int SCRATCH_SEL_BIT = 2;
    localparam int SCALE_WE_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_ERASE_BIT = 1;
    localparam logic [7:0] STORE_CTRL_RST = 8'h00;
    localparam logic [7:0] SCALE_CTRL_RST = 8'h00;

    // ==================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int ERASE_TIME_MS = 12;
    localparam int WRITE_TIME_US = 50;
    localparam int ERASE_CYCLES = ERASE_TIME_MS * (CLK_HZ / 1000);
    localparam int WRITE_CYCLES = WRITE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int TIMER_W = 17;

    // ==================================================
    // Carriers
    typedef struct packed {
        logic erase;
        logic scratch;
        logic [15:0] addr;
        logic [7:0] data;
    } flash_op_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } data_access_t;

endpackage

// ===== flash_op_timer.sv
`timescale 1ns/100ps
module flash_op_timer
    import flash_pkg::*;
#(
    parameter int CNT_W = TIMER_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic [CNT_W-1:0] count,
    output logic done
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic running_r;
    wire lastCycle = running_r && (cnt_r <= CNT_W'(1));

    // Loaded count equals the busy length in cycles
    assign cnt_nxt = start ? count : (running_r ? cnt_r - CNT_W'(1) : cnt_r);
    assign done = lastCycle;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            running_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            running_r <= start || (running_r && !lastCycle);
        end
    end

endmodule

// ===== flash_store.sv
`timescale 1ns/100ps
module flash_store
    import flash_pkg::*;
#(
    parameter int MAIN_N = MAIN_BYTES,
    parameter int SCRATCH_N = SCRATCH_BYTES,
    parameter int PAGE_N = PAGE_BYTES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Operation commit
    input wire logic commit,
    input wire flash_op_t op,
    // Read port
    input wire logic rdScratch,
    input wire logic [15:0] rdAddr,
    output logic [7:0] rdData
);

    localparam int PAGE_W = $clog2(PAGE_N);
    localparam int SCR_W = $clog2(SCRATCH_N);

    logic [7:0] mainMem [MAIN_N];
    logic [7:0] scratchMem [SCRATCH_N];

    wire [SCR_W-1:0] opScrIdx = op.addr[SCR_W-1:0];
    wire [7:0] mainAnd = mainMem[op.addr] & op.data;
    wire [7:0] scrAnd = scratchMem[opScrIdx] & op.data;

    assign rdData = rdScratch ? scratchMem[rdAddr[SCR_W-1:0]] : mainMem[rdAddr];

    // ==================================================
    // Storage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < MAIN_N; i++) begin
                mainMem[i] <= ERASED_BYTE;
            end
            for (int i = 0; i < SCRATCH_N; i++) begin
                scratchMem[i] <= ERASED_BYTE;
            end
        end else if (commit) begin
            if (op.erase && op.scratch) begin
                for (int i = 0; i < SCRATCH_N; i++) begin
                    scratchMem[i] <= ERASED_BYTE;
                end
            end else if (op.erase) begin
                for (int j = 0; j < PAGE_N; j++) begin
                    mainMem[{op.addr[15:PAGE_W], PAGE_W'(j)}] <= ERASED_BYTE;
                end
            end else if (op.scratch) begin
                scratchMem[opScrIdx] <= scrAnd;
            end else begin
                mainMem[op.addr] <= mainAnd;
            end
        end
    end

    // ==================================================
    // Checks
    property p_program_and;
        @(posedge sys_clk) disable iff (!rst_n)
        commit && !op.erase && !op.scratch |=> mainMem[$past(op.addr)] == $past(mainAnd);
    endproperty
    a_program_and: assert property (p_program_and) else $error("program did not AND");

    property p_page_erase;
        @(posedge sys_clk) disable iff (!rst_n)
        commit && op.erase && !op.scratch |=> mainMem[{$past(op.addr[15:PAGE_W]), PAGE_W'(0)}] == ERASED_BYTE
            && mainMem[{$past(op.addr[15:PAGE_W]), {PAGE_W{1'b1}}}] == ERASED_BYTE;
    endproperty
    a_page_erase: assert property (p_page_erase) else $error("page not erased");

endmodule

// ===== flash_program_erase_control.sv
`timescale 1ns/100ps
module flash_program_erase_control
    import flash_pkg::*;
#(
    parameter int ERASE_COUNT = ERASE_CYCLES,
    parameter int WRITE_COUNT = WRITE_CYCLES,
    parameter int IRQ_N = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // Core data-space access
    input wire data_access_t coreReq,
    // External data RAM
    output data_access_t extRam,
    // Core code-space read
    input wire logic codeRd,
    input wire logic codeFetch,
    input wire logic [15:0] codeAddr,
    output logic [7:0] codeRdata,
    // Debug programming port
    input wire logic dbgWr,
    input wire logic dbgScratch,
    input wire logic [15:0] dbgAddr,
    input wire logic [7:0] dbgData,
    output logic dbgReady,
    // Core control
    output logic coreStall,
    input wire logic [IRQ_N-1:0] irqReq,
    output logic [IRQ_N-1:0] irqToCore
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } state_t;

    localparam int WRITE_LEN_I = WRITE_COUNT;
    localparam int ERASE_LEN_I = ERASE_COUNT;

    // ==================================================
    // Control registers
    logic storeWe_r;
    logic storeEe_r;
    logic scratchSel_r;
    logic scaleWe_r;
    logic [7:0] regRdata_r;
    logic [7:0] regRdata_nxt;

    wire wrStore = regWr && (regAddr == REG_STORE_CTRL);
    wire wrScale = regWr && (regAddr == REG_SCALE_CTRL);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            storeWe_r <= STORE_CTRL_RST[STORE_WE_BIT];
            storeEe_r <= STORE_CTRL_RST[STORE_EE_BIT];
            scratchSel_r <= STORE_CTRL_RST[SCRATCH_SEL_BIT];
            scaleWe_r <= SCALE_CTRL_RST[SCALE_WE_BIT];
        end else begin
            if (wrStore) begin
                storeWe_r <= regWdata[STORE_WE_BIT];
                storeEe_r <= regWdata[STORE_EE_BIT];
                scratchSel_r <= regWdata[SCRATCH_SEL_BIT];
            end
            if (wrScale) begin
                scaleWe_r <= regWdata[SCALE_WE_BIT];
            end
        end
    end

    // ==================================================
    // Operation sequencing
    state_t state_r;
    state_t state_nxt;
    flash_op_t op_r;
    flash_op_t coreOp;
    flash_op_t dbgOp;
    logic opDone;

    wire idle = (state_r == ST_IDLE);
    // Redirected write, gated by the software enable
    wire redirect = idle && coreReq.wr && storeWe_r;
    wire coreStart = redirect && scaleWe_r;
    wire dbgStart = idle && dbgWr && !coreStart;
    wire startOp = coreStart || dbgStart;
    wire [TIMER_W-1:0] opCount = coreStart && storeEe_r ? TIMER_W'(ERASE_COUNT) : TIMER_W'(WRITE_COUNT);

    assign coreOp = '{erase: storeEe_r, scratch: scratchSel_r, addr: coreReq.addr, data: coreReq.data};
    assign dbgOp = '{erase: 1'b0, scratch: dbgScratch, addr: dbgAddr, data: dbgData};
    assign dbgReady = idle && !coreStart;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (startOp) begin
                    state_nxt = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (opDone) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            op_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (startOp) begin
                op_r <= coreStart ? coreOp : dbgOp;
            end
        end
    end

    assign coreStall = (state_r == ST_BUSY);

    flash_op_timer #(
        .CNT_W(TIMER_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(startOp),
        .count(opCount),
        .done(opDone)
    );

    // ==================================================
    // Flash storage and code-space reads
    logic [7:0] storeRd;
    logic [7:0] codeRdata_r;
    // Fetches never see the scratchpad sector
    wire readScratch = scratchSel_r && !codeFetch;

    flash_store #(
        .MAIN_N(MAIN_BYTES),
        .SCRATCH_N(SCRATCH_BYTES),
        .PAGE_N(PAGE_BYTES)
    ) u_store (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .commit(opDone),
        .op(op_r),
        .rdScratch(readScratch),
        .rdAddr(codeAddr),
        .rdData(storeRd)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            codeRdata_r <= 8'h00;
        end else if (codeRd) begin
            codeRdata_r <= storeRd;
        end
    end
    assign codeRdata = codeRdata_r;

    // ==================================================
    // External data RAM path
    data_access_t extRam_r;
    data_access_t extRam_nxt;

    always_comb begin
        extRam_nxt = coreReq;
        extRam_nxt.wr = coreReq.wr && idle && !storeWe_r;
        extRam_nxt.rd = coreReq.rd && idle;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            extRam_r <= '0;
        end else begin
            extRam_r <= extRam_nxt;
        end
    end
    assign extRam = extRam_r;

    // ==================================================
    // Interrupt hold
    logic [IRQ_N-1:0] irqHeld_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqHeld_r <= '0;
        end else begin
            irqHeld_r <= coreStall ? (irqHeld_r | irqReq) : '0;
        end
    end
    assign irqToCore = coreStall ? '0 : (irqReq | irqHeld_r);

    // ==================================================
    // Register read
    always_comb begin
        regRdata_nxt = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                REG_STORE_CTRL: begin
                    regRdata_nxt[STORE_WE_BIT] = storeWe_r;
                    regRdata_nxt[STORE_EE_BIT] = storeEe_r;
                    regRdata_nxt[SCRATCH_SEL_BIT] = scratchSel_r;
                end
                REG_SCALE_CTRL: begin
                    regRdata_nxt[SCALE_WE_BIT] = scaleWe_r;
                end
                REG_STATUS: begin
                    regRdata_nxt[STATUS_BUSY_BIT] = coreStall;
                    regRdata_nxt[STATUS_ERASE_BIT] = coreStall && op_r.erase;
                end
                default: begin
                    regRdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_r <= 8'h00;
        end else begin
            regRdata_r <= regRdata_nxt;
        end
    end
    assign regRdata = regRdata_r;

    // ==================================================
    // Checks
    logic [TIMER_W-1:0] busyCnt_r;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busyCnt_r <= '0;
        end else if (startOp) begin
            busyCnt_r <= TIMER_W'(1);
        end else if (coreStall) begin
            busyCnt_r <= busyCnt_r + TIMER_W'(1);
        end
    end

    property p_write_len;
        @(posedge sys_clk) disable iff (!rst_n)
        opDone && !op_r.erase |-> busyCnt_r == TIMER_W'(WRITE_LEN_I) && coreStall;
    endproperty
    a_write_len: assert property (p_write_len) else $error("byte write length wrong");

    property p_erase_len;
        @(posedge sys_clk) disable iff (!rst_n)
        opDone && op_r.erase |-> busyCnt_r == TIMER_W'(ERASE_LEN_I) && coreStall;
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

    property p_stall_run;
        @(posedge sys_clk) disable iff (!rst_n)
        startOp |=> coreStall [*2];
    endproperty
    a_stall_run: assert property (p_stall_run) else $error("core not stalled");

    property p_no_enable;
        @(posedge sys_clk) disable iff (!rst_n)
        redirect && !scaleWe_r && !dbgWr |=> !coreStall && !extRam_r.wr;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("blocked write acted");

    property p_ram_write;
        @(posedge sys_clk) disable iff (!rst_n)
        idle && coreReq.wr && !storeWe_r |=> extRam_r.wr && extRam_r.addr == $past(coreReq.addr);
    endproperty
    a_ram_write: assert property (p_ram_write) else $error("RAM write lost");

    property p_ram_read;
        @(posedge sys_clk) disable iff (!rst_n)
        idle && coreReq.rd |=> extRam_r.rd;
    endproperty
    a_ram_read: assert property (p_ram_read) else $error("data read not sent to RAM");

    property p_enable_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        storeWe_r && !wrStore |=> storeWe_r;
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("write enable dropped");

    property p_irq_mute;
        @(posedge sys_clk) disable iff (!rst_n)
        coreStall |-> irqToCore == '0;
    endproperty
    a_irq_mute: assert property (p_irq_mute) else $error("interrupt passed during stall");

    property p_irq_release;
        @(posedge sys_clk) disable iff (!rst_n)
        coreStall && (irqReq != '0) ##1 !coreStall |-> irqToCore != '0;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("held interrupt lost");

    property p_erase_kind;
        @(posedge sys_clk) disable iff (!rst_n)
        coreStart |=> op_r.erase == $past(storeEe_r);
    endproperty
    a_erase_kind: assert property (p_erase_kind) else $error("wrong operation kind");

endmodule

// ===== core_model.sv
`timescale 1ns/100ps
module core_model
    import flash_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Data space, no interrupt input: writes run with interrupts off
    output data_access_t coreReq,
    input wire logic coreStall,
    // Code space
    output logic codeRd,
    output logic codeFetch,
    output logic [15:0] codeAddr,
    input wire logic [7:0] codeRdata
);
    logic waitExpired;

    initial begin
        waitExpired = 1'b0;
        coreReq = '0;
        codeRd = 1'b0;
        codeFetch = 1'b0;
        codeAddr = 16'h0000;
    end

    // ==================================================
    // Data-space access, issued once the stall ends or after 2000 cycles of waiting
    task automatic dataAccess(input logic wr, input logic [15:0] a, input logic [7:0] d);
        for (int i = 0; i < 2000 && coreStall !== 1'b0; i++) begin
            @(posedge sys_clk);
        end
        if (coreStall !== 1'b0) begin
            waitExpired = 1'b1;
        end
        @(posedge sys_clk);
        coreReq <= '{wr: wr, rd: !wr, addr: a, data: d};
        @(posedge sys_clk);
        // Released lines show the inverse
        coreReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask

    // ==================================================
    // Code-space read
    task automatic codeRead(input logic [15:0] a, input logic fetch, output logic [7:0] d);
        @(posedge sys_clk);
        codeRd <= 1'b1;
        codeAddr <= a;
        codeFetch <= fetch;
        @(posedge sys_clk);
        codeRd <= 1'b0;
        codeAddr <= ~a;
        #1;
        d = codeRdata;
    endtask
endmodule

// ===== test_flash_program_erase_control.sv
`timescale 1ns/100ps
module test_flash_program_erase_control
    import flash_pkg::*;
;
    localparam int WCNT = 8;
    localparam int ECNT = 20;
    logic sys_clk, rst_n, regWr, regRd, codeRd, codeFetch, coreStall;
    logic dbgWr, dbgScratch, dbgReady;
    logic [1:0] regAddr;
    logic [7:0] regWdata, regRdata, codeRdata, dbgData, irqReq, irqToCore;
    logic [15:0] codeAddr, dbgAddr;
    data_access_t coreReq, extRam;
    int n_fail, check_count;

    flash_program_erase_control #(.ERASE_COUNT(ECNT), .WRITE_COUNT(WCNT), .IRQ_N(8)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .coreReq(coreReq), .extRam(extRam), .codeRd(codeRd),
        .codeFetch(codeFetch), .codeAddr(codeAddr), .codeRdata(codeRdata), .dbgWr(dbgWr),
        .dbgScratch(dbgScratch), .dbgAddr(dbgAddr), .dbgData(dbgData), .dbgReady(dbgReady),
        .coreStall(coreStall), .irqReq(irqReq), .irqToCore(irqToCore));
    core_model core (.sys_clk(sys_clk), .coreReq(coreReq), .coreStall(coreStall), .codeRd(codeRd),
        .codeFetch(codeFetch), .codeAddr(codeAddr), .codeRdata(codeRdata));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ==================================================
    // Helpers
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic regRead(input logic [1:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata === e, "register read");
    endtask

    // Write from the core, then measure the stall and the held interrupt
    task automatic coreWr(input logic [15:0] a, input logic [7:0] d, input logic ram, input int cnt);
        int n;
        n = 0;
        core.dataAccess(1'b1, a, d);
        if (core.waitExpired === 1'b1) begin
            chk(1'b0, "core wait expired");
            close_out();
        end
        #1;
        chk(extRam.wr === ram && (!ram || (extRam.addr === a && extRam.data === d)), "ram write");
        while (coreStall === 1'b1 && n < 200) begin
            if (irqReq !== 8'h00) chk(irqToCore === 8'h00, "irq passed during stall");
            if (n == 2) chk(regRdata === ((cnt == ECNT) ? 8'h03 : 8'h01), "status during operation");
            @(posedge sys_clk);
            // One request early, one in the last stall cycle
            irqReq <= (n == 2) ? 8'h04 : ((n == cnt - 2) ? 8'h08 : 8'h00);
            regAddr <= 2'h2;
            regRd <= (n == 0);
            #1;
            n++;
        end
        if (n >= 200) begin
            chk(1'b0, "stall timeout");
            close_out();
        end
        chk(n == cnt && coreStall === 1'b0, "stall length");
        if (cnt > 0) chk(irqToCore === 8'h0c, "held irq not released");
    endtask

    task automatic dataRead(input logic [15:0] a);
        core.dataAccess(1'b0, a, 8'h00);
        if (core.waitExpired === 1'b1) begin
            chk(1'b0, "core wait expired");
            close_out();
        end
        #1;
        chk(extRam.rd === 1'b1 && extRam.wr === 1'b0 && extRam.addr === a, "ram read");
    endtask

    task automatic codeChk(input logic [15:0] a, input logic fetch, input logic [7:0] e);
        logic [7:0] d;
        core.codeRead(a, fetch, d);
        chk(d === e, "code read");
    endtask

    // ==================================================
    // Scenarios
    task automatic t_regs();
        regRead(2'h0, 8'h00);
        regRead(2'h1, 8'h00);
        regRead(2'h2, 8'h00);
        regWrite(2'h0, 8'hff);
        regRead(2'h0, 8'h07);
        regWrite(2'h1, 8'hff);
        regRead(2'h1, 8'h01);
        regWrite(2'h3, 8'hff);
        regRead(2'h3, 8'h00);
        regWrite(2'h0, 8'h00);
        regWrite(2'h1, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_ram();
        coreWr(16'h1234, 8'h5a, 1'b1, 0);
        codeChk(16'h1234, 1'b0, 8'hff);
        dataRead(16'h0042);
        regWrite(2'h0, 8'h01);
        coreWr(16'h1234, 8'h5a, 1'b0, 0);
        codeChk(16'h1234, 1'b0, 8'hff);
        dataRead(16'h0043);
        $display("test ram and blocked done");
    endtask

    task automatic t_program();
        regWrite(2'h1, 8'h01);
        coreWr(16'h1234, 8'h5a, 1'b0, WCNT);
        codeChk(16'h1234, 1'b0, 8'h5a);
        coreWr(16'h1234, 8'hf3, 1'b0, WCNT);
        codeChk(16'h1234, 1'b0, 8'h52);
        coreWr(16'h1400, 8'h11, 1'b0, WCNT);
        coreWr(16'hffff, 8'h3e, 1'b0, WCNT);
        codeChk(16'hffff, 1'b1, 8'h3e);
        regRead(2'h0, 8'h01);
        $display("test program done");
    endtask

    task automatic t_erase();
        regWrite(2'h0, 8'h03);
        coreWr(16'h13ff, 8'h00, 1'b0, ECNT);
        regWrite(2'h0, 8'h01);
        codeChk(16'h1234, 1'b0, 8'hff);
        codeChk(16'h1200, 1'b0, 8'hff);
        codeChk(16'h1400, 1'b0, 8'h11);
        coreWr(16'h1200, 8'h77, 1'b0, WCNT);
        codeChk(16'h1200, 1'b0, 8'h77);
        $display("test erase done");
    endtask

    task automatic t_scratch();
        regWrite(2'h0, 8'h05);
        coreWr(16'h0005, 8'h3c, 1'b0, WCNT);
        codeChk(16'h0005, 1'b0, 8'h3c);
        codeChk(16'h0005, 1'b1, 8'hff);
        regWrite(2'h0, 8'h07);
        coreWr(16'h0010, 8'h00, 1'b0, ECNT);
        codeChk(16'h0005, 1'b0, 8'hff);
        regWrite(2'h0, 8'h01);
        codeChk(16'h0005, 1'b0, 8'hff);
        $display("test scratchpad done");
    endtask

    task automatic t_debug();
        int n;
        regWrite(2'h0, 8'h00);
        regWrite(2'h1, 8'h00);
        @(posedge sys_clk);
        dbgAddr <= 16'h2000;
        dbgData <= 8'ha5;
        dbgWr <= 1'b1;
        @(posedge sys_clk);
        dbgWr <= 1'b0;
        #1;
        chk(dbgReady === 1'b0, "debug write not taken");
        n = 0;
        while (dbgReady !== 1'b1 && n < 200) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(n < 200, "debug write hung");
        if (n >= 200) close_out();
        codeChk(16'h2000, 1'b0, 8'ha5);
        $display("test debug done");
    endtask

    initial begin
        n_fail = 0;
        check_count = 0;
        rst_n = 1'b0;
        {regAddr, regWdata, regWr, regRd} = '0;
        {dbgWr, dbgScratch, dbgAddr, dbgData} = '0;
        irqReq = 8'h00;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_ram();
        t_program();
        t_erase();
        t_scratch();
        t_debug();
        close_out();
    end
endmodule
